/* hw/ssp_defs.svh */
// Purpose: timing and field constants of the synchronous serial port
// Assumes: included by bare name wherever the constants are needed
// Notes:   definitions only
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define SSP_WORD_W       16
`define SSP_CTRL_BITS    5'h08
`define SSP_CTRL_MSB     4'h7
`define SSP_REPLY_START  5'h09
`define SSP_CNT_ONE      5'h01
`define SSP_TICK_ONE     6'h01
`define SSP_TICK_TWO     6'h02
`define SSP_TICK_ZERO    6'h00

// ****************************************************************
// reset values
// ****************************************************************
`define SSP_WORD_RST     16'h0000
`define SSP_DIV_RST      8'h00

`endif

/* hw/ssp_pkg.sv */
// Purpose: shared types of the synchronous serial port
// Assumes: used with ssp_defs.svh
// Notes:   nothing is imported; use ssp_pkg::name
package ssp_pkg;

  // ****************************************************************
  // configuration carrier
  // ****************************************************************
  typedef struct packed
  {
    logic       enable;
    logic       master;
    logic       fmt_ctrl;
    logic       pol;
    logic       ph;
    logic [3:0] size_m1;
    logic [7:0] half_div;
  } ssp_cfg_t;

  // ****************************************************************
  // master sequencer states
  // ****************************************************************
  typedef enum logic [1:0]
  {
    SSP_IDLE,
    SSP_FRAME,
    SSP_END
  } ssp_state_t;

endpackage : ssp_pkg

/* hw/ssp_port.sv */
// Purpose: frame engine of a synchronous serial port, master or slave
// Assumes: cfg only changes while cfg.enable is low
// Notes:   master runs on mclk, slave shifter runs on the pin clock
`timescale 1ns/1ps
`include "ssp_defs.svh"

module ssp_port
(
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire ssp_pkg::ssp_cfg_t cfg,
  input  wire logic             tx_valid,
  input  wire logic [15:0]      tx_data,
  output logic                  tx_ready,
  output logic                  rx_valid,
  output logic [15:0]           rx_data,
  output logic                  busy,
  input  wire logic             serial_clock_pin_i,
  output logic                  serial_clock_pin_o,
  output logic                  serial_clock_pin_oe_n,
  input  wire logic             frame_select_pin_i,
  output logic                  frame_select_pin_o,
  input  wire logic             serial_in_pin,
  output logic                  serial_out_pin,
  output logic                  serial_out_pin_oe_n,
  output logic                  slave_out_pin,
  output logic                  slave_out_pin_oe_n
);

  // keep the low size_m1+1 bits of a word
  function automatic logic [15:0] ssp_mask
  (
    input logic [15:0] w,
    input logic [3:0]  size_m1
  );
    logic [15:0] m;
    m = 16'hFFFF >> (4'hF - size_m1);
    return w & m;
  endfunction : ssp_mask

  // ****************************************************************
  // master sequencer (mclk)
  // ****************************************************************
  ssp_pkg::ssp_state_t state;
  ssp_pkg::ssp_state_t next_state;
  logic [7:0]  tmr;
  logic [7:0]  next_tmr;
  logic [5:0]  tick_n;
  logic [5:0]  next_tick_n;
  logic [15:0] txw;
  logic [15:0] next_txw;
  logic [15:0] rxsh;
  logic [15:0] next_rxsh;
  logic        next_sclk;
  logic        next_fss;
  logic        next_sout;
  logic        next_sout_oe_n;
  logic        next_tx_ready;
  logic        next_rx_valid;
  logic [15:0] next_rx_data;
  logic        in_s1;
  logic        in_s2;
  logic [15:0] slave_word;
  logic [15:0] next_slave_word;
  logic        slave_full;
  logic        next_slave_full;
  logic        tgl_s1;
  logic        tgl_s2;
  logic        tgl_s3;
  logic [15:0] sl_rx_word;
  logic        sl_rx_tgl;
  logic [4:0]  nbits;
  logic [5:0]  last;
  logic        ph1_spi;

  assign nbits   = cfg.fmt_ctrl ? `SSP_REPLY_START + {1'b0, cfg.size_m1} +
                   `SSP_CNT_ONE : {1'b0, cfg.size_m1} + `SSP_CNT_ONE;
  assign last    = {nbits, 1'b0};
  assign ph1_spi = cfg.ph & ~cfg.fmt_ctrl;

  always_comb
  begin
    logic [5:0]  t;
    logic [4:0]  k;
    logic [15:0] cap;
    t               = tick_n + `SSP_TICK_ONE;
    k               = t[5:1];
    cap             = rxsh;
    next_state      = state;
    next_tmr        = tmr;
    next_tick_n     = tick_n;
    next_txw        = txw;
    next_rxsh       = rxsh;
    next_sclk       = serial_clock_pin_o;
    next_fss        = frame_select_pin_o;
    next_sout       = serial_out_pin;
    next_sout_oe_n  = serial_out_pin_oe_n;
    next_tx_ready   = 1'b0;
    next_rx_valid   = 1'b0;
    next_rx_data    = rx_data;
    next_slave_word = slave_word;
    next_slave_full = slave_full;
    case (state)
      ssp_pkg::SSP_IDLE:
      begin
        next_sclk      = cfg.pol & ~cfg.fmt_ctrl;
        next_fss       = 1'b1;
        next_sout      = 1'b0;
        next_sout_oe_n = 1'b1;
        if (cfg.enable && cfg.master && tx_valid)
        begin
          next_txw       = tx_data;
          next_tx_ready  = 1'b1;
          next_fss       = 1'b0;
          next_sout_oe_n = 1'b0;
          next_sout      = cfg.fmt_ctrl & tx_data[`SSP_CTRL_MSB];
          next_tick_n    = `SSP_TICK_ZERO;
          next_tmr       = cfg.half_div;
          next_state     = ssp_pkg::SSP_FRAME;
        end
      end
      ssp_pkg::SSP_FRAME:
      begin
        if (tmr != `SSP_DIV_RST)
        begin
          next_tmr = tmr - 8'h01;
        end
        else
        begin
          next_tmr    = cfg.half_div;
          next_tick_n = t;
          if (ph1_spi ? (t >= `SSP_TICK_ONE && t <= last) :
              (t >= `SSP_TICK_TWO && t <= last + `SSP_TICK_ONE))
          begin
            next_sclk = ~serial_clock_pin_o;
          end
          if (t[0] && t < last)
          begin
            if (cfg.fmt_ctrl)
              next_sout = (k < `SSP_CTRL_BITS) &&
                          txw[`SSP_CTRL_MSB - k[3:0]];
            else
              next_sout = txw[cfg.size_m1 - k[3:0]];
          end
          if (!t[0] && t >= `SSP_TICK_TWO && t <= last)
          begin
            if (!cfg.fmt_ctrl || k > `SSP_REPLY_START)
              cap = {rxsh[14:0], in_s2};
            next_rxsh = cap;
          end
          if (ph1_spi && t == last && cfg.enable && tx_valid)
          begin
            next_txw      = tx_data;
            next_tx_ready = 1'b1;
            next_tick_n   = `SSP_TICK_ZERO;
            next_rx_valid = 1'b1;
            next_rx_data  = ssp_mask(cap, cfg.size_m1);
          end
          else if (cfg.fmt_ctrl && t == last + `SSP_TICK_ONE &&
                   cfg.enable && tx_valid)
          begin
            next_txw      = tx_data;
            next_tx_ready = 1'b1;
            next_tick_n   = `SSP_TICK_ONE;
            next_sout     = tx_data[`SSP_CTRL_MSB];
            next_rx_valid = 1'b1;
            next_rx_data  = ssp_mask(rxsh, cfg.size_m1);
          end
          else if (t == last + `SSP_TICK_TWO)
          begin
            next_fss       = 1'b1;
            next_sout      = 1'b0;
            next_sout_oe_n = 1'b1;
            next_rx_valid  = 1'b1;
            next_rx_data   = ssp_mask(rxsh, cfg.size_m1);
            next_state     = ssp_pkg::SSP_END;
          end
        end
      end
      ssp_pkg::SSP_END:
      begin
        // select stays high a half period before the next word
        if (tmr != `SSP_DIV_RST)
          next_tmr = tmr - 8'h01;
        else
          next_state = ssp_pkg::SSP_IDLE;
      end
      default:
      begin
        next_state = ssp_pkg::SSP_IDLE;
      end
    endcase
    // slave side: hand words to the link shifter, collect replies
    if (cfg.enable && !cfg.master)
    begin
      if (tgl_s3 != tgl_s2)
      begin
        next_rx_valid   = 1'b1;
        next_rx_data    = sl_rx_word;
        next_slave_full = 1'b0;
      end
      else if (!slave_full && tx_valid)
      begin
        next_slave_word = tx_data;
        next_slave_full = 1'b1;
        next_tx_ready   = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state                 <= ssp_pkg::SSP_IDLE;
      tmr                   <= `SSP_DIV_RST;
      tick_n                <= `SSP_TICK_ZERO;
      txw                   <= `SSP_WORD_RST;
      rxsh                  <= `SSP_WORD_RST;
      serial_clock_pin_o    <= 1'b0;
      serial_clock_pin_oe_n <= 1'b1;
      frame_select_pin_o    <= 1'b1;
      serial_out_pin        <= 1'b0;
      serial_out_pin_oe_n   <= 1'b1;
      tx_ready              <= 1'b0;
      rx_valid              <= 1'b0;
      rx_data               <= `SSP_WORD_RST;
      busy                  <= 1'b0;
      slave_word            <= `SSP_WORD_RST;
      slave_full            <= 1'b0;
      in_s1                 <= 1'b0;
      in_s2                 <= 1'b0;
      tgl_s1                <= 1'b0;
      tgl_s2                <= 1'b0;
      tgl_s3                <= 1'b0;
    end
    else
    begin
      state                 <= next_state;
      tmr                   <= next_tmr;
      tick_n                <= next_tick_n;
      txw                   <= next_txw;
      rxsh                  <= next_rxsh;
      serial_clock_pin_o    <= next_sclk;
      serial_clock_pin_oe_n <= ~(cfg.enable & cfg.master);
      frame_select_pin_o    <= next_fss;
      serial_out_pin        <= next_sout;
      serial_out_pin_oe_n   <= next_sout_oe_n;
      tx_ready              <= next_tx_ready;
      rx_valid              <= next_rx_valid;
      rx_data               <= next_rx_data;
      busy                  <= (next_state != ssp_pkg::SSP_IDLE);
      slave_word            <= next_slave_word;
      slave_full            <= next_slave_full;
      in_s1                 <= serial_in_pin;
      in_s2                 <= in_s1;
      tgl_s1                <= sl_rx_tgl;
      tgl_s2                <= tgl_s1;
      tgl_s3                <= tgl_s2;
    end
  end

  // ****************************************************************
  // slave shifter (pin clock, held in reset while deselected)
  // ****************************************************************
  logic        lclk;
  logic        lrst_b;
  logic        sl_act;
  logic [4:0]  cap_cnt;
  logic [4:0]  next_cap_cnt;
  logic [15:0] sl_rx_sh;
  logic [15:0] next_sl_rx_sh;
  logic [15:0] next_sl_rx_word;
  logic        next_sl_rx_tgl;
  logic [4:0]  ne_cnt;
  logic [4:0]  next_ne_cnt;
  logic        sl_out_q;
  logic        next_sl_out_q;
  logic        launched;
  logic        reply_on;
  logic        next_reply_on;
  logic [4:0]  target;

  // phase and polarity fold into one clock: capture rises, launch falls
  assign lclk   = serial_clock_pin_i ^
                  (~cfg.fmt_ctrl & (cfg.pol ^ cfg.ph));
  assign lrst_b = rst_b & ~frame_select_pin_i;
  assign sl_act = cfg.enable & ~cfg.master;
  assign target = cfg.fmt_ctrl ? `SSP_CTRL_BITS :
                  {1'b0, cfg.size_m1} + `SSP_CNT_ONE;

  always_comb
  begin
    next_cap_cnt    = cap_cnt;
    next_sl_rx_sh   = sl_rx_sh;
    next_sl_rx_word = sl_rx_word;
    next_sl_rx_tgl  = sl_rx_tgl;
    if (sl_act && (!cfg.fmt_ctrl || cap_cnt < `SSP_CTRL_BITS))
    begin
      next_sl_rx_sh = {sl_rx_sh[14:0], serial_in_pin};
      next_cap_cnt  = cap_cnt + `SSP_CNT_ONE;
      if (next_cap_cnt == target)
      begin
        next_sl_rx_word = cfg.fmt_ctrl ? {8'h00, next_sl_rx_sh[7:0]} :
                          ssp_mask(next_sl_rx_sh, cfg.size_m1);
        next_sl_rx_tgl  = ~sl_rx_tgl;
        if (!cfg.fmt_ctrl)
          next_cap_cnt = 5'h00;
      end
    end
  end

  always_ff @(posedge lclk or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      cap_cnt  <= 5'h00;
      sl_rx_sh <= `SSP_WORD_RST;
    end
    else
    begin
      cap_cnt  <= next_cap_cnt;
      sl_rx_sh <= next_sl_rx_sh;
    end
  end

  // word and toggle survive deselect so the mclk side can read them
  always_ff @(posedge lclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sl_rx_word <= `SSP_WORD_RST;
      sl_rx_tgl  <= 1'b0;
    end
    else
    begin
      sl_rx_word <= next_sl_rx_word;
      sl_rx_tgl  <= next_sl_rx_tgl;
    end
  end

  always_comb
  begin
    logic [4:0] idx;
    idx           = ne_cnt + {4'h0, ~cfg.ph};
    next_ne_cnt   = ne_cnt + `SSP_CNT_ONE;
    next_sl_out_q = sl_out_q;
    next_reply_on = reply_on;
    if (cfg.fmt_ctrl)
    begin
      idx = ne_cnt - `SSP_CTRL_BITS;
      if (ne_cnt >= `SSP_CTRL_BITS && idx <= {1'b0, cfg.size_m1})
      begin
        next_reply_on = 1'b1;
        next_sl_out_q = slave_word[cfg.size_m1 - idx[3:0]];
      end
      else
        next_sl_out_q = 1'b0;
    end
    else
    begin
      if (idx > {1'b0, cfg.size_m1})
        idx = idx - target;
      next_sl_out_q = slave_word[cfg.size_m1 - idx[3:0]];
      if (next_ne_cnt == target)
        next_ne_cnt = 5'h00;
    end
  end

  always_ff @(negedge lclk or negedge lrst_b)
  begin
    if (!lrst_b)
    begin
      ne_cnt   <= 5'h00;
      sl_out_q <= 1'b0;
      launched <= 1'b0;
      reply_on <= 1'b0;
    end
    else
    begin
      ne_cnt   <= next_ne_cnt;
      sl_out_q <= next_sl_out_q;
      launched <= 1'b1;
      reply_on <= next_reply_on;
    end
  end

  // phase 0 needs the MSB on the line before any clock edge
  assign slave_out_pin      = launched ? sl_out_q :
                              (~cfg.fmt_ctrl & slave_word[cfg.size_m1]);
  assign slave_out_pin_oe_n = frame_select_pin_i | ~sl_act |
                              (cfg.fmt_ctrl & ~reply_on);

endmodule : ssp_port

/* verif/ssp_port_monitor.sv */
// Purpose: concurrent checks on the master side of ssp_port
// Assumes: bound to ssp_port, half_div static while enabled
// Notes:   gap counts mclk cycles since the serial clock last moved
`timescale 1ns/1ps
module ssp_port_monitor
(
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire ssp_pkg::ssp_cfg_t cfg,
  input wire logic              tx_valid,
  input wire logic [15:0]       tx_data,
  input wire logic              tx_ready,
  input wire logic              rx_valid,
  input wire logic              busy,
  input wire logic              serial_clock_pin_o,
  input wire logic              serial_clock_pin_oe_n,
  input wire logic              frame_select_pin_o,
  input wire logic              serial_out_pin,
  input wire logic              serial_out_pin_oe_n
);
  logic       prev_clk;
  logic [8:0] gap;
  logic [8:0] next_gap;
  wire  logic mst = cfg.enable & cfg.master;
  always_comb
  begin
    next_gap = gap;
    if (serial_clock_pin_o != prev_clk)
      next_gap = 9'h001;
    else if (gap != 9'h1FF)
      next_gap = gap + 9'h001;
  end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_clk <= 1'h0;
      gap      <= 9'h000;
    end
    else
    begin
      prev_clk <= serial_clock_pin_o;
      gap      <= next_gap;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    !busy && mst && tx_valid && $past(rst_b);
  endsequence
  sequence s_open;
    tx_ready && !frame_select_pin_o && !serial_out_pin_oe_n;
  endsequence
  property p_idle;
    mst && !busy && $stable(cfg) && $past(rst_b) |-> frame_select_pin_o
      && !serial_out_pin && serial_clock_pin_o == (cfg.pol & !cfg.fmt_ctrl);
  endproperty
  a_idle: assert property (p_idle) else $error("idle lines wrong");
  property p_clk_oe;
    $past(rst_b) && $stable(cfg) |-> serial_clock_pin_oe_n == !mst;
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock enable");
  property p_start;
    s_take |=> s_open;
  endproperty
  a_start: assert property (p_start) else $error("no frame start");
  property p_no_start;
    !cfg.enable && !$past(cfg.enable) |-> !tx_ready && frame_select_pin_o;
  endproperty
  a_no_start: assert property (p_no_start) else $error("started off");
  property p_ctrl_msb;
    s_take ##0 cfg.fmt_ctrl |=> serial_out_pin == $past(tx_data[7]);
  endproperty
  a_ctrl_msb: assert property (p_ctrl_msb) else $error("first bit");
  property p_sel_rx;
    mst && $rose(frame_select_pin_o) |-> rx_valid && serial_out_pin_oe_n;
  endproperty
  a_sel_rx: assert property (p_sel_rx) else $error("word not stored");
  property p_gap;
    mst && $rose(frame_select_pin_o) |-> gap ==
      ((cfg.ph && !cfg.fmt_ctrl) ? {cfg.half_div, 1'h0} + 9'h002 :
       {1'h0, cfg.half_div} + 9'h001);
  endproperty
  a_gap: assert property (p_gap) else $error("select rise late");
  property p_cont;
    mst && (cfg.ph || cfg.fmt_ctrl) && tx_ready && $past(busy) |->
      rx_valid && !frame_select_pin_o ##1 !frame_select_pin_o;
  endproperty
  a_cont: assert property (p_cont) else $error("select left");
endmodule : ssp_port_monitor
bind ssp_port ssp_port_monitor u_ssp_port_monitor
(
  .mclk(mclk), .rst_b(rst_b), .cfg(cfg), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
  .busy(busy), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe_n(serial_clock_pin_oe_n),
  .frame_select_pin_o(frame_select_pin_o), .serial_out_pin(serial_out_pin),
  .serial_out_pin_oe_n(serial_out_pin_oe_n)
);

/* verif/ssp_far_slave.sv */
// Purpose: behavioural serial slave facing the port in master mode
// Assumes: clock stands still outside frames
// Notes:   same reply word for every frame; released line toggles
`timescale 1ns/1ps
module ssp_far_slave
(
  input  wire logic        sclk,
  input  wire logic        fss_n,
  input  wire logic        mosi,
  input  wire logic        pol,
  input  wire logic        ph,
  input  wire logic        ctrl,
  input  wire logic [3:0]  size_m1,
  input  wire logic [15:0] reply,
  output logic             miso,
  output logic [15:0]      got
);
  int idx;
  int rc;
  wire logic cap_rise = ctrl | (pol == ph);
  task launch();
    idx  = (idx + 1) % (size_m1 + 1);
    miso = reply[size_m1 - idx];
  endtask : launch
  always @(fss_n)
  begin
    if (fss_n)
      miso = (miso === 1'h0);
    else
    begin
      got = 16'h0000;
      rc  = 0;
      idx = (ph || ctrl) ? -1 : 0;
      if (!ph && !ctrl)
        miso = reply[size_m1];
    end
  end
  always @(posedge sclk)
  begin
    if (!fss_n)
    begin
      rc = (rc >= 10 + size_m1) ? 1 : rc + 1;
      if (ctrl ? rc <= 8 : cap_rise)
        got = {got[14:0], mosi};
      else if (!ctrl)
        launch();
    end
  end
  always @(negedge sclk)
  begin
    if (!fss_n)
    begin
      if (ctrl)
        miso = (rc >= 9 && rc <= 9 + size_m1) ?
               reply[9 + size_m1 - rc] : !miso;
      else if (!cap_rise)
        got = {got[14:0], mosi};
      else
        launch();
    end
  end
endmodule : ssp_far_slave

/* verif/ssp_port_bench.sv */
// Purpose: self-checking bench of ssp_port, master and slave
// Assumes: half_div of 3, link clock of 12 ns in slave mode
// Notes:   received words are queued at every rx_valid pulse
`timescale 1ns/1ps
module ssp_port_bench;
  typedef struct packed
  {
    logic        ctrl;
    logic        pol;
    logic        ph;
    logic [3:0]  sz;
    logic [15:0] tx;
    logic [15:0] rep;
  } ssp_row_t;
  ssp_pkg::ssp_cfg_t cfg;
  logic mclk, rst_b, tx_valid, tx_ready, rx_valid, busy, m_clk, m_sel;
  logic m_dat, miso, clk_o, clk_oe_n, sel_o, out, out_oe_n, s_out, s_oe_n;
  logic [15:0] tx_data, rx_data, got, rep, sg;
  logic [15:0] rx_q[$];
  int          mismatches, check_count, sel_rises;
  wire logic   sclk_pin = clk_oe_n ? m_clk : clk_o;
  wire logic   sin = cfg.master ? miso : m_dat;
  ssp_row_t    rows [5] = '{
    {1'h0, 1'h0, 1'h1, 4'hF, 16'hA5C3, 16'h3C5A},
    {1'h0, 1'h1, 1'h0, 4'h7, 16'h00B4, 16'h0069},
    {1'h0, 1'h1, 1'h1, 4'h3, 16'h0009, 16'h0006},
    {1'h1, 1'h0, 1'h0, 4'h3, 16'h00C5, 16'h000A},
    {1'h1, 1'h0, 1'h0, 4'hF, 16'h005E, 16'h8001}};
  ssp_port u_ssp_port
  (
    .mclk(mclk), .rst_b(rst_b), .cfg(cfg), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .busy(busy), .serial_clock_pin_i(sclk_pin),
    .serial_clock_pin_o(clk_o), .serial_clock_pin_oe_n(clk_oe_n),
    .frame_select_pin_i(m_sel), .frame_select_pin_o(sel_o),
    .serial_in_pin(sin), .serial_out_pin(out), .serial_out_pin_oe_n(out_oe_n),
    .slave_out_pin(s_out), .slave_out_pin_oe_n(s_oe_n)
  );
  ssp_far_slave u_ssp_far_slave
  (
    .sclk(sclk_pin), .fss_n(sel_o), .mosi(out), .pol(cfg.pol), .ph(cfg.ph),
    .ctrl(cfg.fmt_ctrl), .size_m1(cfg.size_m1), .reply(rep), .miso(miso),
    .got(got)
  );
  initial
  begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) if (rx_valid === 1'h1) rx_q.push_back(rx_data);
  always @(posedge sel_o) sel_rises++;
  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check
  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  function logic [15:0] msk(input logic ctrl, input logic [3:0] sz);
    return ctrl ? 16'h00FF : 16'hFFFF >> (4'hF - sz);
  endfunction : msk
  task set_cfg(input logic c, p, h, m, input logic [3:0] sz);
    int n;
    n = 0;
    while (busy !== 1'h0 && n < 500)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 500) mismatches++;
    cfg.enable = 1'h0;
    @(negedge mclk);
    {cfg.fmt_ctrl, cfg.pol, cfg.ph, cfg.master, cfg.size_m1} = {c, p, h, m, sz};
    @(negedge mclk);
    cfg.enable = 1'h1;
    repeat (2) @(negedge mclk);
    rx_q.delete();
  endtask : set_cfg
  task send(input logic [15:0] w);
    int n;
    n = 0;
    tx_valid = 1'h1;
    tx_data  = w;
    @(negedge mclk);
    while (tx_ready !== 1'h1 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 400) mismatches++;
  endtask : send
  task waitn(input int k);
    int n;
    n = 0;
    while (rx_q.size() < k && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 3000) mismatches++;
  endtask : waitn
  task cont(input logic c, p, h, input int rises);
    set_cfg(c, p, h, 1'h1, 4'h7);
    rep       = 16'h005A;
    sel_rises = 0;
    send(16'h0081);
    send(16'h007E);
    tx_valid = 1'h0;
    waitn(2);
    repeat (20) @(negedge mclk);
    check(16'(sel_rises), 16'(rises));
    check(rx_q[1], 16'h005A);
    check(got & msk(c, 4'h7), 16'h007E);
  endtask : cont
  task slave_run(input logic c, input logic [15:0] w, input int n, e);
    sg    = 16'h0000;
    m_sel = 1'h0;
    m_dat = w[n-1];
    #24;
    for (int r = 0; r < e; r++)
    begin
      m_clk = 1'h1;
      if (!c) m_dat = w[n-1-r];
      else if (r >= 9) sg = {sg[14:0], s_out};
      if (c && r == 3) check(s_oe_n, 16'h0001);
      #6 m_clk = 1'h0;
      if (!c) sg = {sg[14:0], s_out};
      else if (r < 7) m_dat = w[6-r];
      #6;
    end
    #12 m_sel = 1'h1;
  endtask : slave_run
  initial
  begin
    #1000000;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    cfg = '0;
    cfg.half_div = 8'h03;
    {tx_valid, tx_data, m_clk, m_sel, m_dat, rst_b, rep} = '0;
    m_sel = 1'h1;
    repeat (6) @(negedge mclk);
    check(sel_o, 16'h0001);
    check(clk_oe_n, 16'h0001);
    check(rx_data, 16'h0000);
    repeat (6) @(negedge mclk);
    rst_b    = 1'h1;
    tx_valid = 1'h1;
    repeat (20) @(negedge mclk);
    check({busy, sel_o}, 16'h0001);
    tx_valid = 1'h0;
    foreach (rows[i])
    begin
      set_cfg(rows[i].ctrl, rows[i].pol, rows[i].ph, 1'h1, rows[i].sz);
      check(clk_oe_n, 16'h0000);
      rep = rows[i].rep;
      send(rows[i].tx);
      tx_valid = 1'h0;
      waitn(1);
      check(rx_q[0], rows[i].rep);
      check(got & msk(rows[i].ctrl, rows[i].sz), rows[i].tx);
    end
    cont(1'h0, 1'h0, 1'h1, 1);
    cont(1'h0, 1'h1, 1'h0, 2);
    cont(1'h1, 1'h0, 1'h0, 1);
    set_cfg(1'h0, 1'h0, 1'h1, 1'h0, 4'h7);
    check(clk_oe_n, 16'h0001);
    send(16'h00C3);
    tx_valid = 1'h0;
    slave_run(1'h0, 16'h005A, 8, 8);
    waitn(1);
    check(rx_q[0], 16'h005A);
    check(sg & 16'h00FF, 16'h00C3);
    set_cfg(1'h1, 1'h0, 1'h0, 1'h0, 4'h3);
    send(16'h000B);
    tx_valid = 1'h0;
    slave_run(1'h1, 16'h0096, 8, 13);
    waitn(1);
    check(rx_q[0], 16'h0096);
    check(sg & 16'h000F, 16'h000B);
    end_of_test();
  end
endmodule : ssp_port_bench
